// ==== hdl/tac_map.vh ====
`ifndef TAC_MAP_VH
`define TAC_MAP_VH
// Overview of operation
// (R1) Mode 00 performs no conversions and is the reset value.
// (R2) Mode 01 single channel, 10 slave sequence, 11 master sequence.
// (R3) Mode 01 converts once on the channel address field, bits 10:7.
// (R4) Single or slave end with timer 00 clears mode to 00, idle.
// (R5) Single mode with nonzero timer repeats same conversion each interval.
// (R6) Mode 10 converts every slave-enabled channel, each into its own result.
// (R7) Slave sequence with nonzero timer reruns whole sequence per interval.
// (R8) Mode 11 waits for touch, then converts master-enabled channels.
// (R9) Next master sequence only on new touch or timer while touched.
// (R10) Channel address sits in bits 10:7, conversion type in bit 11.
// (R11) Type bit clear gives single-ended, set gives ratiometric, all modes.
// (R12) Channel codes 0 to 10 map to position, pressure, aux, battery, temp.
// (R13) Plate switches per channel: Y pos, X pos, pressure; others off.
// (R14) Timer field: once, 1024, 2048 or 16384 clocks.
// (R15) Slave operation starts timer as soon as the sequence completes.
// (R16) Master operation starts timer at sequence end only if still touched.
// (R17) Master touch release stops timer; next touch converts immediately.
// (R18) Sequence bit 11 selects channel 0, down to bit 1 for channel 10.
// (R19) Host sets mode 00, changes settings, writes control register last.
// (R20) Power management field 00 blocks every conversion.
// (R21) Channel codes 11 to 15 are invalid and start no conversion.
// (R22) Interval counter counts clocks and restarts from zero on each start.

// ----------------------------------------
// Register offsets and reset
// ----------------------------------------
`define TAC_CTRL_OFS 8'h00
`define TAC_TIMING_OFS 8'h04
`define TAC_SSEQ_OFS 8'h08
`define TAC_MSEQ_OFS 8'h0c
`define TAC_STAT_OFS 8'h10
`define TAC_REG_RST 12'h000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TAC_MODE_LSB 0
`define TAC_CHAN_LSB 7
`define TAC_TYPE_BIT 11
`define TAC_TMR_LSB 0
`define TAC_PM_LSB 6

// ----------------------------------------
// Codes
// ----------------------------------------
`define TAC_MODE_OFF 2'h0
`define TAC_MODE_SINGLE 2'h1
`define TAC_MODE_SSEQ 2'h2
`define TAC_MODE_MSEQ 2'h3
`define TAC_PM_DOWN 2'h0
`define TAC_TMR_ONCE 2'h0
`define TAC_CH_YPOS 4'h0
`define TAC_CH_XPOS 4'h1
`define TAC_CH_PRESS_B 4'h2
`define TAC_CH_PRESS_A 4'ha
`define TAC_CH_LAST 4'ha
`define TAC_SEQ_END 4'hb
`define TAC_SEQ_TOP 4'hb
`define TAC_RESP_OKAY 2'h0
`define TAC_RESP_SLVERR 2'h2

// ----------------------------------------
// Repeat intervals in conversion clocks
// ----------------------------------------
`define TAC_RPT_CLK_1 15'h0400
`define TAC_RPT_CLK_2 15'h0800
`define TAC_RPT_CLK_3 15'h4000

`endif

// ==== hdl/tac_chan_dec.v ====
`timescale 1ns/10ps
`include "tac_map.vh"

module tac_chan_dec (
  // Channel code
  input wire [3:0] code,
  // Decode
  output reg valid,
  output reg sw_xp,
  output reg sw_xn,
  output reg sw_yp,
  output reg sw_yn
);

  always @* begin
    valid = (code <= `TAC_CH_LAST); // R12 R21
    sw_xp = 1'b0;
    sw_xn = 1'b0;
    sw_yp = 1'b0;
    sw_yn = 1'b0;
    case (code) // R13
      `TAC_CH_YPOS: begin
        sw_yp = 1'b1;
        sw_yn = 1'b1;
      end
      `TAC_CH_XPOS: begin
        sw_xp = 1'b1;
        sw_xn = 1'b1;
      end
      `TAC_CH_PRESS_A, `TAC_CH_PRESS_B: begin
        sw_xn = 1'b1;
        sw_yp = 1'b1;
      end
      default: begin
        sw_xp = 1'b0;
      end
    endcase
  end

endmodule // tac_chan_dec

// ==== hdl/tac_rpt_timer.v ====
`timescale 1ns/10ps
`include "tac_map.vh"

module tac_rpt_timer #(
  parameter [14:0] CNT_1 = `TAC_RPT_CLK_1,
  parameter [14:0] CNT_2 = `TAC_RPT_CLK_2,
  parameter [14:0] CNT_3 = `TAC_RPT_CLK_3
) (
  // Clock and reset
  input wire aclk,
  input wire aclk_en,
  input wire aresetn,
  // Control
  input wire start,
  input wire stop,
  input wire [1:0] sel,
  // Expiry
  output reg expire_ff
);

  reg [14:0] cnt_ff;
  reg run_ff;
  reg [14:0] lim;

  always @* begin
    case (sel) // R14
      2'h1: lim = CNT_1 - 15'h0001;
      2'h2: lim = CNT_2 - 15'h0001;
      default: lim = CNT_3 - 15'h0001;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 15'h0000;
      run_ff <= 1'b0;
      expire_ff <= 1'b0;
    end else if (aclk_en) begin
      expire_ff <= 1'b0;
      if (stop) begin
        run_ff <= 1'b0;
      end else if (start) begin
        cnt_ff <= 15'h0000; // R22
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff == lim) begin
          run_ff <= 1'b0;
          expire_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 15'h0001; // R22
        end
      end
    end
  end

endmodule // tac_rpt_timer

// ==== hdl/tac_top.v ====
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "tac_map.vh"

module tac_top #(
  parameter [14:0] RPT_CNT_1 = `TAC_RPT_CLK_1,
  parameter [14:0] RPT_CNT_2 = `TAC_RPT_CLK_2,
  parameter [14:0] RPT_CNT_3 = `TAC_RPT_CLK_3
) (
  // Clock, enable, reset
  input wire aclk,
  input wire aclk_en,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  // AXI4-Lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // AXI4-Lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read address
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  // AXI4-Lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Converter handshake
  output reg conv_start_ff,
  output reg [3:0] conv_channel_ff,
  output reg conv_ratiometric_ff,
  input wire conv_done,
  // Touch detect pin
  input wire touch_pin,
  // Plate switches
  output reg sw_xp_ff,
  output reg sw_xn_ff,
  output reg sw_yp_ff,
  output reg sw_yn_ff,
  // Status
  output reg busy_ff
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_PICK = 6'h02;
  localparam [5:0] ST_CONV = 6'h04;
  localparam [5:0] ST_ENDS = 6'h08;
  localparam [5:0] ST_RPT = 6'h10;
  localparam [5:0] ST_TOUCH = 6'h20;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [11:0] ctrl_ff;
  reg [11:0] timing_ff;
  reg [11:0] sseq_ff;
  reg [11:0] mseq_ff;
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [7:0] awaddr_ff;
  reg [11:0] wdata_ff;
  reg [1:0] wstrb_ff;
  reg touch_s1_ff;
  reg touch_s2_ff;
  reg [5:0] state_ff;
  reg [5:0] nxt_state;
  reg [3:0] idx_ff;
  reg [3:0] nxt_idx;
  reg arm_ff;
  reg nxt_arm;
  reg start_conv;
  reg mode_clr;
  reg tmr_start;
  reg tmr_stop;
  reg [3:0] pick_ch;
  reg [11:0] rd_val;
  reg rd_hit;
  wire wr_fire;
  wire wr_hit;
  wire ctrl_wr;
  wire [11:0] wmask;
  wire [1:0] mode;
  wire [1:0] tmr_sel;
  wire [1:0] pm;
  wire [3:0] ch_addr;
  wire [11:0] seq_en;
  wire touch;
  wire halt;
  wire ch_valid;
  wire dec_xp;
  wire dec_xn;
  wire dec_yp;
  wire dec_yn;
  wire tmr_expire;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  assign mode = ctrl_ff[`TAC_MODE_LSB +: 2];
  assign ch_addr = ctrl_ff[`TAC_CHAN_LSB +: 4]; // R3 R10
  assign tmr_sel = timing_ff[`TAC_TMR_LSB +: 2];
  assign pm = timing_ff[`TAC_PM_LSB +: 2];
  assign seq_en = (mode == `TAC_MODE_MSEQ) ? mseq_ff : sseq_ff;
  assign touch = touch_s2_ff;

  // ----------------------------------------
  // Touch synchroniser
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      touch_s1_ff <= 1'b0;
      touch_s2_ff <= 1'b0;
    end else if (aclk_en) begin
      touch_s1_ff <= touch_pin;
      touch_s2_ff <= touch_s1_ff;
    end
  end

  // ----------------------------------------
  // Channel decode and repeat timer
  // ----------------------------------------
  tac_chan_dec u_dec (
    .code(pick_ch),
    .valid(ch_valid),
    .sw_xp(dec_xp),
    .sw_xn(dec_xn),
    .sw_yp(dec_yp),
    .sw_yn(dec_yn)
  );

  tac_rpt_timer #(
    .CNT_1(RPT_CNT_1),
    .CNT_2(RPT_CNT_2),
    .CNT_3(RPT_CNT_3)
  ) u_tmr (
    .aclk(aclk),
    .aclk_en(aclk_en),
    .aresetn(aresetn),
    .start(tmr_start),
    .stop(tmr_stop),
    .sel(tmr_sel),
    .expire_ff(tmr_expire)
  );

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign wr_fire = aw_hold_ff & w_hold_ff & ~bvalid;
  assign wr_hit = (awaddr_ff[7:2] <= `TAC_MSEQ_OFS >> 2);
  assign ctrl_wr = wr_fire & (awaddr_ff[7:2] == `TAC_CTRL_OFS >> 2);
  assign wmask = {{4{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 12'h000;
      wstrb_ff <= 2'h0;
      bvalid <= 1'b0;
      bresp <= `TAC_RESP_OKAY;
    end else if (aclk_en) begin
      if (awvalid && awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= awaddr;
        awready <= 1'b0;
      end else if (!aw_hold_ff && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= wdata[11:0];
        wstrb_ff <= wstrb[1:0];
        wready <= 1'b0;
      end else if (!w_hold_ff && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `TAC_RESP_OKAY : `TAC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `TAC_REG_RST; // R1
      timing_ff <= `TAC_REG_RST;
      sseq_ff <= `TAC_REG_RST;
      mseq_ff <= `TAC_REG_RST;
    end else if (aclk_en) begin
      if (ctrl_wr) begin
        ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff & wmask);
      end else if (mode_clr) begin
        ctrl_ff[`TAC_MODE_LSB +: 2] <= `TAC_MODE_OFF; // R4
      end
      if (wr_fire && awaddr_ff[7:2] == `TAC_TIMING_OFS >> 2) begin
        timing_ff <= (timing_ff & ~wmask) | (wdata_ff & wmask);
      end
      if (wr_fire && awaddr_ff[7:2] == `TAC_SSEQ_OFS >> 2) begin
        sseq_ff <= (sseq_ff & ~wmask) | (wdata_ff & wmask);
      end
      if (wr_fire && awaddr_ff[7:2] == `TAC_MSEQ_OFS >> 2) begin
        mseq_ff <= (mseq_ff & ~wmask) | (wdata_ff & wmask);
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always @* begin
    rd_hit = 1'b1;
    case (araddr[7:2])
      `TAC_CTRL_OFS >> 2: rd_val = ctrl_ff;
      `TAC_TIMING_OFS >> 2: rd_val = timing_ff;
      `TAC_SSEQ_OFS >> 2: rd_val = sseq_ff;
      `TAC_MSEQ_OFS >> 2: rd_val = mseq_ff;
      `TAC_STAT_OFS >> 2: rd_val = {state_ff, idx_ff, touch, busy_ff};
      default: begin
        rd_val = 12'h000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TAC_RESP_OKAY;
    end else if (aclk_en) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {20'h00000, rd_val};
        rresp <= rd_hit ? `TAC_RESP_OKAY : `TAC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  assign halt = ctrl_wr | (mode == `TAC_MODE_OFF) | (pm == `TAC_PM_DOWN); // R1 R19 R20

  always @* begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_arm = arm_ff;
    start_conv = 1'b0;
    mode_clr = 1'b0;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    pick_ch = (mode == `TAC_MODE_SINGLE) ? ch_addr : idx_ff; // R3
    if (halt) begin
      nxt_state = ST_IDLE;
      tmr_stop = 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_idx = 4'h0;
          if (mode == `TAC_MODE_MSEQ) begin // R2
            nxt_state = ST_TOUCH; // R8
            nxt_arm = 1'b1;
          end else begin
            nxt_state = ST_PICK;
          end
        end
        ST_PICK: begin
          if (mode == `TAC_MODE_SINGLE) begin
            if (ch_valid) begin // R21
              start_conv = 1'b1;
              nxt_state = ST_CONV;
            end else begin
              nxt_state = ST_ENDS;
            end
          end else if (idx_ff == `TAC_SEQ_END) begin
            nxt_state = ST_ENDS;
          end else if (seq_en[`TAC_SEQ_TOP - idx_ff]) begin // R18 R6
            start_conv = 1'b1;
            nxt_state = ST_CONV;
          end else begin
            nxt_idx = idx_ff + 4'h1;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            nxt_idx = idx_ff + 4'h1;
            nxt_state = (mode == `TAC_MODE_SINGLE) ? ST_ENDS : ST_PICK;
          end
        end
        ST_ENDS: begin
          nxt_idx = 4'h0;
          if (mode != `TAC_MODE_MSEQ) begin
            if (tmr_sel == `TAC_TMR_ONCE) begin
              mode_clr = 1'b1; // R4
              nxt_state = ST_IDLE;
            end else begin
              tmr_start = 1'b1; // R15 R5 R7
              nxt_state = ST_RPT;
            end
          end else if (touch && tmr_sel != `TAC_TMR_ONCE) begin
            tmr_start = 1'b1; // R16
            nxt_state = ST_RPT;
          end else begin
            nxt_arm = ~touch; // R9
            nxt_state = ST_TOUCH;
          end
        end
        ST_RPT: begin
          if (mode == `TAC_MODE_MSEQ && !touch) begin
            tmr_stop = 1'b1; // R17
            nxt_arm = 1'b1;
            nxt_state = ST_TOUCH;
          end else if (tmr_expire) begin
            nxt_state = ST_PICK; // R5 R7 R9
          end
        end
        ST_TOUCH: begin
          nxt_idx = 4'h0;
          if (!touch) begin
            nxt_arm = 1'b1;
          end else if (arm_ff) begin
            nxt_arm = 1'b0;
            nxt_state = ST_PICK; // R8 R17
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer state and converter outputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      arm_ff <= 1'b0;
      conv_start_ff <= 1'b0;
      conv_channel_ff <= 4'h0;
      conv_ratiometric_ff <= 1'b0;
      sw_xp_ff <= 1'b0;
      sw_xn_ff <= 1'b0;
      sw_yp_ff <= 1'b0;
      sw_yn_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (aclk_en) begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      arm_ff <= nxt_arm;
      conv_start_ff <= start_conv;
      busy_ff <= (nxt_state == ST_CONV);
      if (start_conv) begin
        conv_channel_ff <= pick_ch; // R12
        conv_ratiometric_ff <= ctrl_ff[`TAC_TYPE_BIT]; // R11
        sw_xp_ff <= dec_xp; // R13
        sw_xn_ff <= dec_xn;
        sw_yp_ff <= dec_yp;
        sw_yn_ff <= dec_yn;
      end else if (nxt_state != ST_CONV) begin
        sw_xp_ff <= 1'b0;
        sw_xn_ff <= 1'b0;
        sw_yp_ff <= 1'b0;
        sw_yn_ff <= 1'b0;
      end
    end
  end

endmodule // tac_top

// ==== sim/tac_properties.sv ====
`timescale 1ns/10ps
module tac_properties (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Converter
  input wire conv_start_ff,
  input wire [3:0] conv_channel_ff,
  input wire conv_done,
  input wire busy_ff,
  // Plates
  input wire sw_xp_ff,
  input wire sw_xn_ff,
  input wire sw_yp_ff,
  input wire sw_yn_ff
);
  wire [3:0] sw = {sw_xp_ff, sw_xn_ff, sw_yp_ff, sw_yn_ff};
  wire [3:0] ch = conv_channel_ff;
  // ----
  // Checks
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ypos_sw_a: assert property (conv_start_ff && ch == 4'h0 |-> sw == 4'h3)
    else $error("bad Y switches");
  xpos_sw_a: assert property (conv_start_ff && ch == 4'h1 |-> sw == 4'hc)
    else $error("bad X switches");
  press_sw_a: assert property (conv_start_ff && (ch == 4'h2 || ch == 4'ha) |-> sw == 4'h6)
    else $error("bad pressure switches");
  other_sw_a: assert property (conv_start_ff && ch inside {[4'h3:4'h9]} |-> sw == 4'h0)
    else $error("switches on");
  done_off_a: assert property (busy_ff && conv_done |=> !busy_ff && sw == 4'h0)
    else $error("no release at done");
  chan_ok_a: assert property (conv_start_ff |-> ch <= 4'ha && busy_ff)
    else $error("bad start");
  start_one_a: assert property (conv_start_ff |=> !conv_start_ff [*2])
    else $error("start too long");
  busy_cause_a: assert property ($rose(busy_ff) |-> conv_start_ff)
    else $error("busy without start");
endmodule // tac_properties

bind tac_top tac_properties u_props (.aclk, .aresetn, .conv_start_ff, .conv_channel_ff,
  .conv_done, .busy_ff, .sw_xp_ff, .sw_xn_ff, .sw_yp_ff, .sw_yn_ff);

// ==== sim/tac_adc_model.sv ====
`timescale 1ns/10ps
module tac_adc_model (
  // Clock
  input wire aclk,
  // Converter handshake
  input wire conv_start_ff,
  input wire [7:0] lat,
  output reg done_ff
);
  int cnt_ff = -1;
  initial done_ff = 1'b0;
  // One-cycle done, lat+1 cycles after each start is sampled
  always @(posedge aclk) begin
    done_ff <= 1'b0;
    if (conv_start_ff) begin
      cnt_ff <= lat;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
    end else if (cnt_ff == 0) begin
      done_ff <= 1'b1;
      cnt_ff <= -1;
    end
  end
endmodule // tac_adc_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`include "tac_map.vh"
module tb_top;
  logic aclk, aclk_en, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, conv_start_ff, conv_ratiometric_ff, conv_done;
  logic touch_pin, busy_ff, sw_xp_ff, sw_xn_ff, sw_yp_ff, sw_yn_ff;
  logic [7:0] awaddr, araddr, lat;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb, conv_channel_ff;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [4:0] st_c[$];
  int st_t[$];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, g, rpt;

  tac_top #(.RPT_CNT_1(15'd40), .RPT_CNT_2(15'd60), .RPT_CNT_3(15'd80)) DUT (
    .aclk, .aclk_en, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .conv_start_ff, .conv_channel_ff, .conv_ratiometric_ff, .conv_done,
    .touch_pin, .sw_xp_ff, .sw_xn_ff, .sw_yp_ff, .sw_yn_ff, .busy_ff);
  tac_adc_model u_adc (.aclk, .conv_start_ff, .lat, .done_ff(conv_done));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Log every start; cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (conv_start_ff === 1'b1) begin
      st_t.push_back(cyc);
      st_c.push_back({conv_ratiometric_ff, conv_channel_ff});
    end
    if (cyc == 30000) begin
      err_total++;
      give_verdict;
    end
  end

  // ----
  // Tasks
  // ----
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    wr_r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a);
    logic t;
    t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(posedge aclk);
      t = arready;
    end
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task idle(int k);
    repeat (k) @(posedge aclk);
  endtask

  task wait_off;
    n = 0;
    do begin
      rd(`TAC_CTRL_OFS);
      n++;
    end while (rd_d[1:0] !== 2'h0 && n < 60);
    chk("mode cleared", rd_d[1:0], 2'h0);
  endtask

  task clr;
    st_t.delete();
    st_c.delete();
  endtask

  // ----
  // Tests
  // ----
  initial begin
    {aclk_en, aresetn, awvalid, wvalid, bready, arvalid, rready, touch_pin} = 8'h80;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    lat = 8'h02;
    idle(4);
    aresetn <= 1'b1;
    idle(2);
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk("reset value", rd_d, (i == 4) ? 32'h40 : 32'h0);
      chk("read resp", rd_r, 2'h0);
    end
    rd(8'h14);
    chk("unmapped read", rd_d, 32'h0);
    chk("unmapped rresp", rd_r, 2'h2);
    wr(8'h14, 32'hfff);
    chk("unmapped write", wr_r, 2'h2);
    wr(`TAC_CTRL_OFS, 32'h181);
    chk("write resp", wr_r, 2'h0);
    idle(30);
    chk("powered down", st_t.size(), 0);
    wr(`TAC_CTRL_OFS, 32'h0);
    wr(`TAC_TIMING_OFS, 32'h40);
    for (int i = 0; i < 32; i++) begin
      lat = i[0] ? 8'h14 : 8'h01;
      clr();
      wr(`TAC_CTRL_OFS, {20'h0, i[4], i[3:0], 7'h01});
      wait_off();
      chk("single count", st_c.size(), i[3:0] < 11);
      if (i[3:0] < 11) chk("single chan", st_c[0], i[4:0]);
    end
    lat = 8'h02;
    wr(`TAC_SSEQ_OFS, 32'h805);
    clr();
    wr(`TAC_CTRL_OFS, 32'h2);
    wait_off();
    chk("slave count", st_c.size(), 2);
    chk("slave first", st_c[0], 5'h00);
    chk("slave second", st_c[1], 5'h09);
    for (int k = 1; k < 4; k++) begin
      rpt = 20 + 20 * k;
      wr(`TAC_TIMING_OFS, 32'h40 | k);
      clr();
      wr(`TAC_CTRL_OFS, 32'h181);
      idle(rpt * 3);
      wr(`TAC_CTRL_OFS, 32'h0);
      n = st_t.size();
      g = st_t[1] - st_t[0];
      chk("repeats", n >= 3, 1);
      chk("interval", g >= rpt && g <= rpt + 15, 1);
      idle(100);
      chk("stopped", st_t.size(), n);
    end
    wr(`TAC_TIMING_OFS, 32'h41);
    clr();
    wr(`TAC_CTRL_OFS, 32'h2);
    idle(100);
    wr(`TAC_CTRL_OFS, 32'h0);
    chk("seq rerun", st_t.size() >= 4 && st_t[2] - st_t[1] >= 40, 1);
    wr(`TAC_TIMING_OFS, 32'h40);
    wr(`TAC_MSEQ_OFS, 32'h400);
    clr();
    wr(`TAC_CTRL_OFS, 32'h3);
    idle(40);
    chk("wait touch", st_t.size(), 0);
    touch_pin <= 1'b1;
    aclk_en <= 1'b0;
    idle(30);
    chk("frozen", st_t.size(), 0);
    aclk_en <= 1'b1;
    idle(30);
    chk("touch start", st_c.size(), 1);
    chk("touch chan", st_c[0], 5'h01);
    idle(60);
    chk("no retrigger", st_t.size(), 1);
    touch_pin <= 1'b0;
    idle(10);
    touch_pin <= 1'b1;
    idle(30);
    chk("new touch", st_t.size(), 2);
    wr(`TAC_CTRL_OFS, 32'h0);
    wr(`TAC_TIMING_OFS, 32'h41);
    clr();
    wr(`TAC_CTRL_OFS, 32'h3);
    idle(100);
    chk("touched repeat", st_t.size() >= 2, 1);
    touch_pin <= 1'b0;
    idle(10);
    n = st_t.size();
    idle(100);
    chk("timer stopped", st_t.size(), n);
    touch_pin <= 1'b1;
    idle(10);
    chk("immediate start", st_t.size(), n + 1);
    give_verdict;
  end
endmodule // tb_top
